// ===== design/tcp_pkg.sv
package tcp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_DEADBAND = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_IRQSEL = 8'h20;
  // control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_REL_LO = 3;
  localparam int CTRL_CLK_LO = 6;
  localparam int CTRL_COMP_EN = 8;
  // status and irq select bits
  localparam int EV_TC = 0;
  localparam int EV_CMP = 1;
  localparam int EV_CAP = 2;
  localparam int EV_W = 3;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [31:0] UNMAPPED = 32'h00000000;

  typedef enum logic [1:0] {
    TCP_FREE_RUN,
    TCP_ONE_SHOT,
    TCP_ENABLE_RUN
  } tcp_mode_t;

  typedef enum logic [2:0] {
    less_than_relation,
    less_or_equal_relation,
    same_value_relation,
    at_least_relation,
    greater_than_relation
  } tcp_rel_t;

  // compare of count against threshold
  function automatic logic tcp_compare(input logic [2:0] rel, input logic [15:0] cnt,
                                       input logic [15:0] thr);
    unique case (rel)
      3'h0: tcp_compare = cnt < thr;
      3'h1: tcp_compare = cnt <= thr;
      3'h2: tcp_compare = cnt == thr;
      3'h3: tcp_compare = cnt >= thr;
      3'h4: tcp_compare = cnt > thr;
      default: tcp_compare = 1'b0;
    endcase
  endfunction
endpackage

// ===== design/tcp_tick_if.sv
`timescale 1ns/10ps
interface tcp_tick_if;
  logic tick;
  logic [1:0] sel;
  modport src (input sel, output tick);
  modport dst (output sel, input tick);
endinterface

// ===== design/tcp_clksel.sv
`timescale 1ns/10ps
module tcp_clksel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] ext_clk,
  tcp_tick_if.src tk
);
  typedef struct packed {
    logic [1:0] prev;
    logic [1:0] div;
    logic tick;
  } tcp_cs_t;
  tcp_cs_t r, next_r;

  // counting tick: system clock, divide by four, or rising edge of an external source
  always_comb begin
    next_r = r;
    next_r.prev = ext_clk;
    next_r.div = r.div + 2'h1;
    // R12: selectable tick source
    unique case (tk.sel)
      2'h0: next_r.tick = 1'b1;
      2'h1: next_r.tick = (r.div == 2'h3);
      2'h2: next_r.tick = ext_clk[0] & ~r.prev[0];
      default: next_r.tick = ext_clk[1] & ~r.prev[1];
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign tk.tick = r.tick;
endmodule

// ===== design/tcp_deadband.sv
`timescale 1ns/10ps
module tcp_deadband (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic pwm_raw,
  input wire logic kill,
  input wire logic comp_en,
  input wire logic [7:0] dead_len,
  output logic pwm_true,
  output logic pwm_comp
);
  typedef struct packed {
    logic last;
    logic [7:0] cnt;
    logic pt;
    logic pc;
  } tcp_db_t;
  tcp_db_t r, next_r;

  always_comb begin
    next_r = r;
    if (tick) begin
      next_r.last = pwm_raw;
      // R14: equal dead time
      if (pwm_raw != r.last) begin
        next_r.cnt = dead_len;
      end else if (r.cnt != 8'h00) begin
        next_r.cnt = r.cnt - 8'h01;
      end
    end
    // R11: both off in deadband
    next_r.pt = r.last & (r.cnt == 8'h00) & (pwm_raw == r.last);
    next_r.pc = ~r.last & (r.cnt == 8'h00) & (pwm_raw == r.last) & comp_en;
    // R9: kill forces inactive
    if (kill) begin
      next_r.pt = 1'b0;
      next_r.pc = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign pwm_true = r.pt;
  assign pwm_comp = r.pc;
endmodule

// ===== design/tcp_timer.sv
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// Function
// R1: the counter is sixteen bits and only counts down.
// R2: the period is loaded on start, on the reset input and at terminal count.
// R3: the compare uses one selectable relation of five against the threshold.
// R4: the interrupt is selectable among terminal count, compare true and capture.
// R5: outputs are compare, terminal count, complementary compare and one interrupt.
// R6: the unit runs free, as a one shot, or under an enable input.
// R7: a one shot stops at the end of the period instead of reloading.
// R8: under enable control the count moves only while enable is high.
// R9: reset and capture inputs exist, and kill forces the compare outputs inactive.
// R10: capture stores the full sixteen-bit count.
// R11: true and complementary outputs have a dead interval at each change.
// R12: the counting clock is selectable and the count is readable while running.
// R13: terminal count is a one-tick pulse when the count reaches zero; the code drives it for one system clock, not one tick.
// R14: the dead interval is a programmable number of ticks on both rising edges.
module tcp_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] ext_clk,
  input wire logic timer_reset,
  input wire logic capture_in,
  input wire logic enable_in,
  input wire logic kill_in,
  output logic compare_out,
  output logic compare_n_out,
  output logic tc_out,
  output logic irq
);
  typedef struct packed {
    logic running;
    logic start;
    logic [1:0] mode;
    logic [2:0] rel;
    logic [1:0] clk_sel;
    logic comp_en;
    logic [15:0] period;
    logic [15:0] compare;
    logic [7:0] dead;
    logic [15:0] count;
    logic [15:0] capture;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] irq_sel;
    logic cap_prev;
    logic tc;
    logic cmp;
    logic irq;
    logic ack;
    logic [31:0] dat;
    logic out_c;
    logic out_cn;
    logic out_t;
  } tcp_state_t;
  tcp_state_t r, next_r;

  tcp_tick_if tk ();
  logic tick;
  logic pwm_t;
  logic pwm_c;
  logic wr;
  logic rd;
  logic cmp_now;
  logic cap_ev;
  logic [2:0] ev;
  logic [31:0] rdata;

  // tick source picked by control field
  assign tk.sel = r.clk_sel;
  assign tick = tk.tick;

  tcp_clksel u_clksel (
    .clk(clk),
    .reset_n(reset_n),
    .ext_clk(ext_clk),
    .tk(tk)
  );

  tcp_deadband u_dead (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .pwm_raw(r.cmp),
    .kill(kill_in),
    .comp_en(r.comp_en),
    .dead_len(r.dead),
    .pwm_true(pwm_t),
    .pwm_comp(pwm_c)
  );

  // bus strobes, one access per ack
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~r.ack;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~r.ack;

  // R3: relation compare
  assign cmp_now = tcp_pkg::tcp_compare(r.rel, r.count, r.compare);
  // R9: capture taken on rising edge
  assign cap_ev = capture_in & ~r.cap_prev;

  // read mux
  always_comb begin
    rdata = tcp_pkg::UNMAPPED;
    unique case (wb_adr_i)
      tcp_pkg::ADDR_CTRL: rdata = {23'h000000, r.comp_en, r.clk_sel, r.rel, r.mode, r.running};
      tcp_pkg::ADDR_PERIOD: rdata = {16'h0000, r.period};
      tcp_pkg::ADDR_COMPARE: rdata = {16'h0000, r.compare};
      tcp_pkg::ADDR_DEADBAND: rdata = {24'h000000, r.dead};
      // R12: live count read
      tcp_pkg::ADDR_COUNT: rdata = {16'h0000, r.count};
      tcp_pkg::ADDR_CAPTURE: rdata = {16'h0000, r.capture};
      tcp_pkg::ADDR_STATUS: rdata = {29'h00000000, r.status};
      tcp_pkg::ADDR_MASK: rdata = {29'h00000000, r.mask};
      tcp_pkg::ADDR_IRQSEL: rdata = {29'h00000000, r.irq_sel};
      default: rdata = tcp_pkg::UNMAPPED;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.tc = 1'b0;
    next_r.cap_prev = capture_in;
    next_r.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    if (rd) begin
      next_r.dat = rdata;
    end

    // register writes, low lanes only matter
    if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        tcp_pkg::ADDR_CTRL: begin
          next_r.start = wb_dat_i[tcp_pkg::CTRL_START];
          if (!wb_dat_i[tcp_pkg::CTRL_START]) begin
            next_r.running = 1'b0;
          end
          next_r.mode = wb_dat_i[tcp_pkg::CTRL_MODE_LO +: 2];
          next_r.rel = wb_dat_i[tcp_pkg::CTRL_REL_LO +: 3];
          next_r.clk_sel = wb_dat_i[tcp_pkg::CTRL_CLK_LO +: 2];
        end
        tcp_pkg::ADDR_PERIOD: next_r.period[7:0] = wb_dat_i[7:0];
        tcp_pkg::ADDR_COMPARE: next_r.compare[7:0] = wb_dat_i[7:0];
        tcp_pkg::ADDR_DEADBAND: next_r.dead = wb_dat_i[7:0];
        tcp_pkg::ADDR_MASK: next_r.mask = wb_dat_i[2:0];
        tcp_pkg::ADDR_IRQSEL: next_r.irq_sel = wb_dat_i[2:0];
        default: next_r.dead = r.dead;
      endcase
    end
    if (wr && wb_sel_i[1]) begin
      unique case (wb_adr_i)
        tcp_pkg::ADDR_CTRL: next_r.comp_en = wb_dat_i[tcp_pkg::CTRL_COMP_EN];
        tcp_pkg::ADDR_PERIOD: next_r.period[15:8] = wb_dat_i[15:8];
        tcp_pkg::ADDR_COMPARE: next_r.compare[15:8] = wb_dat_i[15:8];
        default: next_r.dead = next_r.dead;
      endcase
    end

    // counting engine
    if (r.start) begin
      // R2: reload on start
      next_r.count = r.period;
      next_r.running = 1'b1;
    end else if (timer_reset) begin
      // R2: reload on reset input
      next_r.count = r.period;
    end else if (r.running && tick) begin
      // R6: mode gates counting
      // R8: hold while enable low
      if (r.mode != 2'(tcp_pkg::TCP_ENABLE_RUN) || enable_in) begin
        if (r.count == tcp_pkg::ZERO16) begin
          // R13: one clock terminal pulse
          next_r.tc = 1'b1;
          // R2: reload at terminal count
          next_r.count = r.period;
          // R7: one shot halts
          if (r.mode == 2'(tcp_pkg::TCP_ONE_SHOT)) begin
            next_r.running = 1'b0;
            next_r.count = tcp_pkg::ZERO16;
          end
        end else begin
          // R1: sixteen bit down count
          next_r.count = r.count - 16'h0001;
        end
      end
    end

    // R10: full width capture
    if (cap_ev) begin
      next_r.capture = r.count;
    end
    next_r.cmp = cmp_now;
    // R5: pin outputs live in the state, one flop each
    next_r.out_c = pwm_t;
    next_r.out_cn = pwm_c;
    next_r.out_t = r.tc;

    // R4: event select, set beats clear
    ev = 3'h0;
    ev[tcp_pkg::EV_TC] = next_r.tc;
    ev[tcp_pkg::EV_CMP] = cmp_now & ~r.cmp;
    ev[tcp_pkg::EV_CAP] = cap_ev;
    ev = ev & r.irq_sel;
    if (wr && wb_sel_i[0] && wb_adr_i == tcp_pkg::ADDR_STATUS) begin
      next_r.status = r.status & ~wb_dat_i[2:0];
    end
    next_r.status = next_r.status | ev;
    // R5: single interrupt line
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.period <= tcp_pkg::PERIOD_RST;
      r.count <= tcp_pkg::PERIOD_RST;
    end else begin
      r <= next_r;
    end
  end

  // pins straight from the state register
  assign compare_out = r.out_c;
  assign compare_n_out = r.out_cn;
  assign tc_out = r.out_t;
  assign irq = r.irq;
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
endmodule

// ===== sim/tcp_timer_sva.sv
`timescale 1ns/10ps
module tcp_timer_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic kill_in,
  input wire logic compare_out,
  input wire logic compare_n_out,
  input wire logic tc_out,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_tc_pulse: assert property (tc_out |=> !tc_out)
    else $error("tc wider than one cycle");
  a_kill_quiet: assert property (kill_in [*3] |-> !compare_out && !compare_n_out)
    else $error("output active under kill");
  a_no_overlap: assert property (!(compare_out && compare_n_out))
    else $error("both outputs active");
  a_dead_true: assert property ($fell(compare_out) |=> !compare_n_out)
    else $error("no gap after true fall");
  a_dead_comp: assert property ($fell(compare_n_out) |=> !compare_out)
    else $error("no gap after complement fall");
  // irq may only drop after a register write
  a_irq_clear: assert property ($fell(irq) |-> $past(wb_we_i && wb_stb_i) ||
    $past(wb_we_i && wb_stb_i, 2))
    else $error("irq dropped without write");
  c_tc: cover property (tc_out);
  c_irq: cover property ($rose(irq));
  c_pair: cover property ($fell(compare_out) ##[1:40] compare_n_out);
endmodule
bind tcp_timer tcp_timer_sva u_sva (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_ack_o, .kill_in, .compare_out, .compare_n_out, .tc_out, .irq);

// ===== sim/tcp_fabric_model.sv
`timescale 1ns/10ps
module tcp_fabric_model (
  input wire logic clk,
  input wire logic reset_n,
  output logic [1:0] ext_clk
);
  logic [2:0] div;
  // routed count sources
  // slow sources so a tick never lands on every system edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div <= 3'h0;
    else div <= div + 3'h1;
  end
  assign ext_clk = {div[2], div[1]};
endmodule

// ===== sim/timer_counter_pwm_16bit_tb_top.sv
`timescale 1ns/10ps
module timer_counter_pwm_16bit_tb_top;
  logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
  logic trst = 0, cap = 0, en = 0, kill = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic ack, cmp, cmpn, tc, irq;
  logic [1:0] ext;
  int error_cnt = 0, check_count = 0;
  always #5 clk = ~clk;
  tcp_fabric_model fab (.clk(clk), .reset_n(reset_n), .ext_clk(ext));
  tcp_timer uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_clk(ext), .timer_reset(trst), .capture_in(cap), .enable_in(en), .kill_in(kill),
    .compare_out(cmp), .compare_n_out(cmpn), .tc_out(tc), .irq(irq));
  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic t_reset;
    rchk(tcp_pkg::ADDR_PERIOD, 32'h0000FFFF);
    rchk(tcp_pkg::ADDR_COUNT, 32'h0000FFFF);
    rchk(8'h40, 32'h00000000);
  endtask
  task automatic t_oneshot;
    int i;
    bus(1'b1, tcp_pkg::ADDR_IRQSEL, 32'h7);
    bus(1'b1, tcp_pkg::ADDR_PERIOD, 32'h5);
    bus(1'b1, tcp_pkg::ADDR_CTRL, 32'h3);
    i = 0;
    while (tc !== 1'b1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, tc}, 32'h1);
    repeat (20) @(posedge clk);
    rchk(tcp_pkg::ADDR_COUNT, 32'h0);
    bus(1'b0, tcp_pkg::ADDR_CTRL, 32'h0);
    chk({31'h0, rd[tcp_pkg::CTRL_START]}, 32'h0);
    bus(1'b0, tcp_pkg::ADDR_STATUS, 32'h0);
    chk({31'h0, rd[tcp_pkg::EV_TC]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, tcp_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, tcp_pkg::ADDR_STATUS, 32'h7);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_hold;
    logic [31:0] h;
    bus(1'b1, tcp_pkg::ADDR_PERIOD, 32'hBEEF);
    bus(1'b1, tcp_pkg::ADDR_CTRL, 32'h5);
    repeat (4) @(posedge clk);
    rchk(tcp_pkg::ADDR_COUNT, 32'hBEEF);
    en <= 1'b1;
    repeat (10) @(posedge clk);
    en <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b0, tcp_pkg::ADDR_COUNT, 32'h0);
    h = rd;
    // ten enabled ticks of the system clock source
    chk(h, 32'h0000BEE5);
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(tcp_pkg::ADDR_CAPTURE, h);
    rchk(tcp_pkg::ADDR_COUNT, h);
    trst <= 1'b1;
    repeat (2) @(posedge clk);
    trst <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(tcp_pkg::ADDR_COUNT, 32'hBEEF);
  endtask
  // each relation over ten periods; ticks every fourth clock
  task automatic t_pwm;
    int h, hn, e;
    int tk[5] = '{4, 5, 1, 6, 5};
    bus(1'b1, tcp_pkg::ADDR_PERIOD, 32'h9);
    bus(1'b1, tcp_pkg::ADDR_COMPARE, 32'h4);
    bus(1'b1, tcp_pkg::ADDR_DEADBAND, 32'h0);
    hn = 0;
    for (int r = 0; r < 5; r++) begin
      bus(1'b1, tcp_pkg::ADDR_CTRL, 32'h101 | (r << 3) | ((r % 2) ? 32'h40 : 32'h80));
      repeat (20) @(posedge clk);
      h = 0;
      e = tk[r] * 40;
      repeat (400) begin
        @(posedge clk);
        h += cmp;
        hn += cmpn;
      end
      chk({31'h0, h <= e && h + 30 >= e}, 32'h1);
    end
    chk({31'h0, hn > 0}, 32'h1);
    // two dead ticks on the eight-clock source; true output loses them plus one sampling tick each period
    bus(1'b1, tcp_pkg::ADDR_DEADBAND, 32'h2);
    bus(1'b1, tcp_pkg::ADDR_CTRL, 32'h1D9);
    repeat (100) @(posedge clk);
    h = 0;
    e = 240;
    repeat (400) begin
      @(posedge clk);
      h += cmp;
    end
    chk({31'h0, h + 90 <= e && h + 130 >= e}, 32'h1);
    kill <= 1'b1;
    repeat (4) @(posedge clk);
    chk({30'h0, cmp, cmpn}, 32'h0);
    kill <= 1'b0;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_oneshot;
    t_hold;
    t_pwm;
    conclude;
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude;
  end
endmodule
